// File: rtl/led_setup_regs.sv
// How it works
// - Setpoint reaches converter on on-input rise.
// - Setpoint: two upper bits, eight lower.
// - Per-channel range register scales output current.
// - Writing 01h to begin register starts operation.
// - A0h selects 5 V overvoltage threshold.
// - 50h enables headroom self-calibration.
// - 2Fh enables overvoltage guard, 7 A limit.
// - 8Fh selects internal converter feedback.
// - 80h at 0x03 disables converter speed-up.
// - Setup negative-limit value means 7 A.
// - Disable pin blanks outputs or selects low power.
// - Each channel's on-input activates that channel.
`timescale 1ns/1ps
`default_nettype none

module led_setup_regs
	import led_setup_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Device pins
	input wire logic [NUM_CH-1:0] channel_on_input,
	input wire logic disable_lowpower_pin,
	// Channel converter controls
	output logic [NUM_CH-1:0][SET_W-1:0] channel_setpoint,
	output logic [NUM_CH-1:0][7:0] channel_scale,
	output logic [NUM_CH-1:0] channel_drive,
	output logic low_power_active,
	// Converter controls
	output logic operation_started,
	output logic headroom_cal_enable,
	output logic speedup_disable,
	output logic ov_threshold_5v,
	output logic ov_protect_enable,
	output logic pos_limit_7a,
	output logic feedback_internal,
	output logic neg_limit_7a,
	output logic neg_limit_final
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [NUM_CH-1:0] on_meta;
	logic [NUM_CH-1:0] on_sync;
	logic dis_meta;
	logic dis_sync;
	logic dis_prev;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			on_meta <= '0;
			on_sync <= '0;
			dis_meta <= 1'b0;
			dis_sync <= 1'b0;
			dis_prev <= 1'b0;
		end else begin
			on_meta <= channel_on_input;
			on_sync <= on_meta;
			dis_meta <= disable_lowpower_pin;
			dis_sync <= dis_meta;
			dis_prev <= dis_sync;
		end
	end

	// Clearing on release, not on assert, keeps the loaded values usable
	// for low-power operation while the pin is held.
	wire dis_release;
	assign dis_release = dis_prev & ~dis_sync;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire [IDX_W-1:0] idx;
	wire aligned;
	wire setup_phase;
	wire wr_en;
	wire [NUM_REGS-1:0] slot_hit;
	wire table_hit;
	wire pin_mode_hit;
	wire status_hit;
	wire mapped;

	assign idx = paddr[IDX_W+1:2];
	assign aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:IDX_W+2] == '0);
	assign setup_phase = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	assign table_hit = |slot_hit;
	assign pin_mode_hit = aligned && (idx == IDX_PIN_MODE);
	assign status_hit = aligned && (idx == IDX_STATUS);
	assign mapped = table_hit | pin_mode_hit | status_hit;

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] regs [NUM_REGS];
	logic [7:0] pin_mode;

	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g++) begin : gen_slot
			assign slot_hit[g] = aligned && (idx == REG_INDEX[g]);
			always_ff @(posedge clk) begin
				if (!rstn) begin
					regs[g] <= REG_RESET;
				end else if (wr_en && slot_hit[g]) begin
					regs[g] <= pwdata[7:0];
				end else if (dis_release) begin
					regs[g] <= REG_RESET;
				end
			end
		end
	endgenerate

	// The disable pin does not clear this one, so its choice outlives a cycle.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pin_mode <= REG_RESET;
		end else if (wr_en && pin_mode_hit) begin
			pin_mode <= pwdata[7:0];
		end
	end

	// ----------------------------------------
	// Start of operation
	// ----------------------------------------
	wire begin_write;
	assign begin_write = wr_en && aligned && (idx == IDX_BEGIN);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			operation_started <= 1'b0;
		end else if (begin_write && (pwdata[7:0] == VAL_BEGIN)) begin
			operation_started <= 1'b1;
		end else if (dis_release) begin
			operation_started <= 1'b0;
		end
	end

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	wire lp_select;
	wire outputs_blanked;
	wire [NUM_CH-1:0] pending;
	wire [NUM_CH-1:0] next_drive;

	assign lp_select = pin_mode[PIN_MODE_LP_BIT];
	assign outputs_blanked = dis_sync & ~lp_select;

	generate
		for (g = 0; g < NUM_CH; g++) begin : gen_ch
			channel_if chif ();
			localparam int BASE = SLOT_CH_BASE + g * SLOT_CH_STEP;
			assign chif.upper = regs[BASE][UPPER_W-1:0];
			assign chif.lower = regs[BASE + 1];
			assign chif.scale = regs[BASE + 2];
			assign chif.on_level = on_sync[g];
			assign chif.clear = dis_release;
			assign channel_setpoint[g] = chif.setpoint;
			assign channel_scale[g] = chif.scale_out;
			assign pending[g] = chif.pending;
			// A release clears the start flag at this edge, so drive must drop with it.
			assign next_drive[g] = operation_started & ~dis_release & on_sync[g] &
				~outputs_blanked;

			channel_latch u_latch (
				.clk(clk),
				.rstn(rstn),
				.ch(chif.channel)
			);
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!rstn) begin
			channel_drive <= '0;
			low_power_active <= 1'b0;
		end else begin
			channel_drive <= next_drive;
			low_power_active <= dis_sync & lp_select;
		end
	end

	// ----------------------------------------
	// Converter control decode
	// ----------------------------------------
	wire next_cal;
	wire next_speedup_off;
	wire next_ov_5v;
	wire next_pos_ov;
	wire next_fb_int;
	wire next_neg_7a;

	assign next_cal = regs[SLOT_MODE_A] == VAL_CAL_ENABLE;
	assign next_speedup_off = regs[SLOT_SPEEDUP] == VAL_SPEEDUP_OFF;
	assign next_ov_5v = regs[SLOT_OV] == VAL_OV_5V;
	assign next_pos_ov = regs[SLOT_POS] == VAL_POS_OV;
	assign next_fb_int = regs[SLOT_FBSEL] == VAL_FB_INTERNAL;
	assign next_neg_7a = regs[SLOT_NEG][6:0] == VAL_NEG_7A;

	// Registered so every converter control leaves on a clean flop edge.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			headroom_cal_enable <= 1'b0;
			speedup_disable <= 1'b0;
			ov_threshold_5v <= 1'b0;
			ov_protect_enable <= 1'b0;
			pos_limit_7a <= 1'b0;
			feedback_internal <= 1'b0;
			neg_limit_7a <= 1'b0;
			neg_limit_final <= 1'b0;
		end else begin
			headroom_cal_enable <= next_cal;
			speedup_disable <= next_speedup_off;
			ov_threshold_5v <= next_ov_5v;
			ov_protect_enable <= next_pos_ov;
			pos_limit_7a <= next_pos_ov;
			feedback_internal <= next_fb_int;
			neg_limit_7a <= next_neg_7a;
			neg_limit_final <= regs[SLOT_NEG][NEG_FINAL_BIT];
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [7:0] table_data;
	wire [7:0] status_data;
	wire [7:0] read_byte;

	always_comb begin
		table_data = 8'h00;
		for (int i = 0; i < NUM_REGS; i++) begin
			if (slot_hit[i]) begin
				table_data = table_data | regs[i];
			end
		end
	end

	assign status_data = {
		pending,
		on_sync,
		dis_sync,
		operation_started
	};
	assign read_byte = status_hit ? status_data :
		pin_mode_hit ? pin_mode : table_data;

	// ----------------------------------------
	// APB answer
	// ----------------------------------------
	// No wait state: the answer is prepared in the setup cycle so
	// that pready, prdata and pslverr all leave straight from flops.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup_phase;
			if (setup_phase) begin
				prdata <= (pwrite || !mapped) ? 32'h0000_0000 : {24'h00_0000, read_byte};
				pslverr <= ~mapped;
			end else if (pready) begin
				prdata <= 32'h0000_0000;
				pslverr <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// File: rtl/led_setup_pkg.sv
package led_setup_pkg;

	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int NUM_CH = 3;
	localparam int NUM_REGS = 31;
	localparam int ADDR_W = 12;
	localparam int UPPER_W = 2;
	localparam int LOWER_W = 8;
	localparam int SET_W = UPPER_W + LOWER_W;
	localparam int IDX_W = 8;

	// ----------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------
	localparam logic [7:0] IDX_MODE_A = 8'h00;
	localparam logic [7:0] IDX_MODE_B = 8'h01;
	localparam logic [7:0] IDX_SPEEDUP = 8'h03;
	localparam logic [7:0] IDX_CH0_FB = 8'h05;
	localparam logic [7:0] IDX_CH1_FB = 8'h06;
	localparam logic [7:0] IDX_CH2_FB = 8'h07;
	localparam logic [7:0] IDX_THERMAL = 8'h08;
	localparam logic [7:0] IDX_CH0_UPPER = 8'h10;
	localparam logic [7:0] IDX_CH0_LOWER = 8'h11;
	localparam logic [7:0] IDX_CH0_RANGE = 8'h12;
	localparam logic [7:0] IDX_CH1_UPPER = 8'h14;
	localparam logic [7:0] IDX_CH1_LOWER = 8'h15;
	localparam logic [7:0] IDX_CH1_RANGE = 8'h16;
	localparam logic [7:0] IDX_CH2_UPPER = 8'h18;
	localparam logic [7:0] IDX_CH2_LOWER = 8'h19;
	localparam logic [7:0] IDX_CH2_RANGE = 8'h1a;
	localparam logic [7:0] IDX_OV = 8'h1f;
	localparam logic [7:0] IDX_CONV_MODE = 8'h20;
	localparam logic [7:0] IDX_CONV_AUX = 8'h22;
	localparam logic [7:0] IDX_FB_SETUP = 8'h24;
	localparam logic [7:0] IDX_CH0_HEAD = 8'h27;
	localparam logic [7:0] IDX_CH0_LOOP = 8'h28;
	localparam logic [7:0] IDX_CH1_HEAD = 8'h2b;
	localparam logic [7:0] IDX_CH1_LOOP = 8'h2c;
	localparam logic [7:0] IDX_CH2_HEAD = 8'h2f;
	localparam logic [7:0] IDX_CH2_LOOP = 8'h30;
	localparam logic [7:0] IDX_NEG = 8'h61;
	localparam logic [7:0] IDX_POS = 8'h62;
	localparam logic [7:0] IDX_FBSEL = 8'h63;
	localparam logic [7:0] IDX_GENERAL = 8'h64;
	localparam logic [7:0] IDX_BEGIN = 8'h72;
	localparam logic [7:0] IDX_PIN_MODE = 8'h80;
	localparam logic [7:0] IDX_STATUS = 8'h81;

	localparam logic [7:0] REG_INDEX [NUM_REGS] = '{
		IDX_MODE_A, IDX_MODE_B, IDX_SPEEDUP, IDX_CH0_FB, IDX_CH1_FB, IDX_CH2_FB,
		IDX_THERMAL, IDX_CH0_UPPER, IDX_CH0_LOWER, IDX_CH0_RANGE, IDX_CH1_UPPER,
		IDX_CH1_LOWER, IDX_CH1_RANGE, IDX_CH2_UPPER, IDX_CH2_LOWER, IDX_CH2_RANGE,
		IDX_OV, IDX_CONV_MODE, IDX_CONV_AUX, IDX_FB_SETUP, IDX_CH0_HEAD,
		IDX_CH0_LOOP, IDX_CH1_HEAD, IDX_CH1_LOOP, IDX_CH2_HEAD, IDX_CH2_LOOP,
		IDX_NEG, IDX_POS, IDX_FBSEL, IDX_GENERAL, IDX_BEGIN
	};

	// ----------------------------------------
	// Storage slots of registers that steer logic
	// ----------------------------------------
	localparam int SLOT_MODE_A = 0;
	localparam int SLOT_SPEEDUP = 2;
	localparam int SLOT_CH_BASE = 7;
	localparam int SLOT_CH_STEP = 3;
	localparam int SLOT_OV = 16;
	localparam int SLOT_NEG = 26;
	localparam int SLOT_POS = 27;
	localparam int SLOT_FBSEL = 28;

	// ----------------------------------------
	// Values and fields
	// ----------------------------------------
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] VAL_CAL_ENABLE = 8'h50;
	localparam logic [7:0] VAL_SPEEDUP_OFF = 8'h80;
	localparam logic [7:0] VAL_OV_5V = 8'ha0;
	localparam logic [7:0] VAL_POS_OV = 8'h2f;
	localparam logic [7:0] VAL_FB_INTERNAL = 8'h8f;
	localparam logic [6:0] VAL_NEG_7A = 7'h15;
	localparam logic [7:0] VAL_BEGIN = 8'h01;
	localparam int NEG_FINAL_BIT = 7;
	localparam int PIN_MODE_LP_BIT = 0;
	localparam int STAT_STARTED = 0;
	localparam int STAT_DISABLE = 1;
	localparam int STAT_ON = 2;
	localparam int STAT_PEND = 5;

endpackage

// File: rtl/channel_if.sv
`timescale 1ns/1ps
`default_nettype none

interface channel_if;
	logic [1:0] upper;
	logic [7:0] lower;
	logic [7:0] scale;
	logic on_level;
	logic clear;
	logic [9:0] setpoint;
	logic [7:0] scale_out;
	logic pending;

	modport bank (
		output upper, lower, scale, on_level, clear,
		input setpoint, scale_out, pending
	);
	modport channel (
		input upper, lower, scale, on_level, clear,
		output setpoint, scale_out, pending
	);
endinterface

`default_nettype wire

// File: rtl/channel_latch.sv
`timescale 1ns/1ps
`default_nettype none

module channel_latch
	import led_setup_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bank side
	channel_if.channel ch
);

	logic on_prev;
	logic [SET_W-1:0] setpoint;
	logic [7:0] scale_out;
	wire on_rise;
	wire [SET_W-1:0] written;

	assign on_rise = ch.on_level & ~on_prev;
	assign written = {ch.upper, ch.lower};
	assign ch.setpoint = setpoint;
	assign ch.scale_out = scale_out;
	assign ch.pending = (written != setpoint) || (ch.scale != scale_out);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			on_prev <= 1'b0;
		end else begin
			on_prev <= ch.on_level;
		end
	end

	// A held-high on input never reloads; only a fresh rising edge does.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			setpoint <= '0;
			scale_out <= REG_RESET;
		end else if (on_rise) begin
			setpoint <= written;
			scale_out <= ch.scale;
		end else if (ch.clear) begin
			setpoint <= '0;
			scale_out <= REG_RESET;
		end
	end

endmodule

`default_nettype wire

// File: verification/led_setup_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module led_setup_regs_monitor
	import led_setup_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Controls
	input wire logic [NUM_CH-1:0] channel_drive,
	input wire logic operation_started,
	input wire logic headroom_cal_enable,
	input wire logic speedup_disable,
	input wire logic ov_threshold_5v,
	input wire logic ov_protect_enable,
	input wire logic pos_limit_7a,
	input wire logic feedback_internal,
	input wire logic neg_limit_7a
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire wr;
	wire [7:0] ix;
	wire [7:0] wd;
	wire [6:0] wn;
	assign wr = psel && penable && pready && pwrite && paddr[1:0] == 2'h0 && paddr[11:10] == 2'h0;
	assign ix = paddr[9:2];
	assign wd = pwdata[7:0];
	assign wn = pwdata[6:0];
	// ----
	// Decodes follow the stored byte both ways.
	// ----
	property dec(i, v, o);
		wr && ix == i |-> ##2 o == ($past(wd, 2) == v);
	endproperty
	AST_READY: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a single cycle after setup");
	AST_CAL: assert property (dec(IDX_MODE_A, VAL_CAL_ENABLE, headroom_cal_enable))
		else $error("calibration enable wrong");
	AST_SPEEDUP: assert property (dec(IDX_SPEEDUP, VAL_SPEEDUP_OFF, speedup_disable))
		else $error("speed-up disable wrong");
	AST_OV: assert property (dec(IDX_OV, VAL_OV_5V, ov_threshold_5v))
		else $error("overvoltage threshold wrong");
	AST_POS: assert property (dec(IDX_POS, VAL_POS_OV, ov_protect_enable && pos_limit_7a))
		else $error("positive limit decode wrong");
	AST_FB: assert property (dec(IDX_FBSEL, VAL_FB_INTERNAL, feedback_internal))
		else $error("feedback select wrong");
	AST_NEG: assert property (wr && ix == IDX_NEG |-> ##2 neg_limit_7a == ($past(wn, 2) == VAL_NEG_7A))
		else $error("negative limit decode wrong");
	AST_START: assert property (wr && ix == IDX_BEGIN && wd == VAL_BEGIN |-> ##2 operation_started)
		else $error("operation did not start");
	AST_DRIVE: assert property (|channel_drive |-> operation_started)
		else $error("channel driven before start");
	cover property (wr && ix == IDX_BEGIN && wd == VAL_BEGIN);
	cover property ($rose(channel_drive[0]));
	cover property (ov_threshold_5v && neg_limit_7a);
endmodule
`default_nettype wire

// File: verification/led_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module led_host_model
	import led_setup_pkg::*;
(
	// Clock
	input wire logic clk,
	// Bus
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic pready
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// Released address and data lines flip so a stale value is never mistaken for a fresh one.
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~{24'h0, d};
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		xfer(1'b1, {2'h0, i, 2'h0}, d);
	endtask
	// ----
	// Power-up load, repeated after every disable cycle.
	// ----
	task automatic setup();
		wr(IDX_MODE_A, VAL_CAL_ENABLE);
		wr(IDX_SPEEDUP, VAL_SPEEDUP_OFF);
		wr(IDX_OV, VAL_OV_5V);
		wr(IDX_POS, VAL_POS_OV);
		wr(IDX_FBSEL, VAL_FB_INTERNAL);
		wr(IDX_NEG, {1'b0, VAL_NEG_7A});
		for (int c = 0; c < NUM_CH; c++) wr(IDX_CH0_HEAD + 8'(4 * c), 8'h7f);
		wr(IDX_BEGIN, VAL_BEGIN);
		wr(IDX_NEG, {1'b1, VAL_NEG_7A});
	endtask
endmodule
`default_nettype wire

// File: verification/tb_led_setup_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_led_setup_regs import led_setup_pkg::*;;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [NUM_CH-1:0] channel_on_input = '0;
	logic disable_lowpower_pin = 1'b0;
	wire psel, penable, pwrite, pready, pslverr;
	wire [ADDR_W-1:0] paddr;
	wire [31:0] pwdata, prdata;
	wire [NUM_CH-1:0][SET_W-1:0] channel_setpoint;
	wire [NUM_CH-1:0][7:0] channel_scale;
	wire [NUM_CH-1:0] channel_drive;
	wire low_power_active, operation_started, headroom_cal_enable, speedup_disable;
	wire ov_threshold_5v, ov_protect_enable, pos_limit_7a, feedback_internal;
	wire neg_limit_7a, neg_limit_final;
	int n_fail = 0;
	int num_checks = 0;
	logic [9:0] q[$];
	logic [7:0] shadow [NUM_REGS];
	led_setup_regs led_setup_regs_i (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .channel_on_input(channel_on_input),
		.disable_lowpower_pin(disable_lowpower_pin), .channel_setpoint(channel_setpoint),
		.channel_scale(channel_scale), .channel_drive(channel_drive),
		.low_power_active(low_power_active), .operation_started(operation_started),
		.headroom_cal_enable(headroom_cal_enable), .speedup_disable(speedup_disable),
		.ov_threshold_5v(ov_threshold_5v), .ov_protect_enable(ov_protect_enable),
		.pos_limit_7a(pos_limit_7a), .feedback_internal(feedback_internal),
		.neg_limit_7a(neg_limit_7a), .neg_limit_final(neg_limit_final));
	led_host_model led_host_model_i (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));
	always #25 clk = ~clk;
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	function automatic logic [ADDR_W-1:0] ba(input logic [7:0] i);
		return {2'h0, i, 2'h0};
	endfunction
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [9:0] e);
		q.push_back(e);
		led_host_model_i.xfer(1'b0, a, 8'h00);
	endtask
	// ----
	// Read results against the oldest note.
	// ----
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) begin
			chk({pslverr, |prdata[31:8], prdata[7:0]}, q.pop_front());
		end
	end
	initial begin
		#1000000;
		n_fail++;
		test_done;
	end
	initial begin
		int c;
		int r;
		logic [7:0] v;
		void'($urandom(78));
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		for (r = 0; r < NUM_REGS; r++) rd(ba(REG_INDEX[r]), 10'h000);
		for (r = 0; r < NUM_REGS; r++) begin
			shadow[r] = 8'($urandom);
			led_host_model_i.wr(REG_INDEX[r], shadow[r]);
		end
		for (r = 0; r < NUM_REGS; r++) rd(ba(REG_INDEX[r]), {2'b00, shadow[r]});
		rd(ba(8'h02), 10'h200);
		rd(12'h001, 10'h200);
		led_host_model_i.setup();
		repeat (3) @(posedge clk);
		chk({speedup_disable, headroom_cal_enable, ov_threshold_5v, ov_protect_enable,
			pos_limit_7a, feedback_internal, neg_limit_7a, neg_limit_final,
			operation_started}, 10'h1ff);
		for (c = 0; c < NUM_CH; c++) begin
			v = 8'($urandom);
			led_host_model_i.wr(IDX_CH0_UPPER + 8'(4 * c), {6'h2a, v[1:0]});
			led_host_model_i.wr(IDX_CH0_LOWER + 8'(4 * c), ~v);
			led_host_model_i.wr(IDX_CH0_RANGE + 8'(4 * c), v);
			repeat (4) @(posedge clk);
			chk(channel_setpoint[c], 10'h000);
			channel_on_input[c] <= 1'b1;
			repeat (5) @(posedge clk);
			chk(channel_setpoint[c], {v[1:0], ~v});
			chk({1'b0, channel_scale[c], channel_drive[c]}, {1'b0, v, 1'b1});
			led_host_model_i.wr(IDX_CH0_LOWER + 8'(4 * c), v);
			repeat (4) @(posedge clk);
			chk(channel_setpoint[c], {v[1:0], ~v});
		end
		rd(ba(IDX_STATUS), 10'h0fd);
		disable_lowpower_pin <= 1'b1;
		repeat (5) @(posedge clk);
		chk({6'h00, channel_drive, low_power_active}, 10'h000);
		disable_lowpower_pin <= 1'b0;
		repeat (5) @(posedge clk);
		chk({channel_setpoint[1][8:0], operation_started}, 10'h000);
		rd(ba(IDX_CH1_LOWER), 10'h000);
		led_host_model_i.setup();
		led_host_model_i.wr(IDX_PIN_MODE, 8'(1 << PIN_MODE_LP_BIT));
		rd(ba(IDX_PIN_MODE), {2'b00, 8'(1 << PIN_MODE_LP_BIT)});
		disable_lowpower_pin <= 1'b1;
		repeat (5) @(posedge clk);
		chk({6'h00, channel_drive, low_power_active}, 10'h00f);
		test_done;
	end
endmodule
bind led_setup_regs led_setup_regs_monitor led_setup_regs_monitor_i (.clk(clk), .rstn(rstn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .channel_drive(channel_drive), .operation_started(operation_started),
	.headroom_cal_enable(headroom_cal_enable), .speedup_disable(speedup_disable),
	.ov_threshold_5v(ov_threshold_5v), .ov_protect_enable(ov_protect_enable),
	.pos_limit_7a(pos_limit_7a), .feedback_internal(feedback_internal),
	.neg_limit_7a(neg_limit_7a));
`default_nettype wire
